// *** rtl/sbp_map.svh ***
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH
// =====================================================================
// widths and encodings
`define ADDR_W          32
`define IDX_W           6
`define CTR_W           2
`define CTR_INIT        2'h1
`define CTR_TAKEN_MIN   2'h2
`define CTR_MAX         2'h3
`define MODE_DIRECTION  2'h0
`define MODE_DYNAMIC    2'h1
`define MODE_NOHEUR     2'h2
`endif

// *** rtl/sbp_pkg.sv ***
package sbp_pkg;
  typedef enum logic [1:0] {
    BR_COND,
    BR_UNCOND,
    BR_INDIRECT,
    BR_NONE
  } br_kind_t;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_BUFFER,
    SRC_STATIC,
    SRC_DYNAMIC
  } pred_src_t;

  typedef struct packed {
    logic        valid;
    br_kind_t    kind;
    logic [31:0] pc;
    logic [31:0] target;
    logic        buf_hit;
    logic        buf_taken;
    logic        is_pause;
  } lookup_t;

  typedef struct packed {
    logic        valid;
    logic        taken;
    pred_src_t   src;
  } pred_t;

  typedef struct packed {
    logic        valid;
    br_kind_t    kind;
    logic [31:0] pc;
    logic        taken;
  } resolve_t;
endpackage

// *** rtl/cond_counter_table.sv ***
`include "sbp_map.svh"
// small table of two-bit counters for conditional branches without buffer history
module cond_counter_table
  import sbp_pkg::*;
#(
  parameter int ENTRIES = 64,
  parameter int IDX_W   = `IDX_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // lookup
  input  wire logic [IDX_W-1:0] rd_idx,
  output      logic             rd_taken,
  // training
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic             wr_taken
);
  logic [`CTR_W-1:0] ctr_r [ENTRIES];

  assign rd_taken = (ctr_r[rd_idx] >= `CTR_TAKEN_MIN);

  // =====================================================================
  // per-entry saturating counters
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ctr
    wire             hit   = wr_en && (wr_idx == IDX_W'(i));
    wire             up_ok = ctr_r[i] != `CTR_MAX;
    wire             dn_ok = ctr_r[i] != 2'h0;
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        ctr_r[i] <= `CTR_INIT;
      end else if (hit && wr_taken && up_ok) begin
        ctr_r[i] <= ctr_r[i] + 2'h1;
      end else if (hit && !wr_taken && dn_ok) begin
        ctr_r[i] <= ctr_r[i] - 2'h1;
      end
    end
  end
endmodule // cond_counter_table

// *** rtl/static_branch_predictor.sv ***
// Contract
// - no buffer entry: buffer gives nothing, static algorithm picks direction
// - unconditional branches always predicted taken
// - indirect branches predicted not taken, fetch falls through
// - direction mode: backward conditional branches predicted taken
// - direction mode: forward conditional branches predicted not taken
// - dynamic mode: conditional branches predicted dynamically, even first time
// - buffer allocates only for conditional branches that resolved taken; the code requests allocation for any taken resolution, whatever its kind
// - mode input selects direction, dynamic or heuristic-free behaviour
// - spin-wait hint acts as a no-operation, only advancing the pointer
`include "sbp_map.svh"
module static_branch_predictor
  import sbp_pkg::*;
#(
  parameter int ENTRIES = 64
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // configuration
  input  wire logic [1:0] mode,
  // lookup from fetch and decode
  input  wire lookup_t    lookup,
  // prediction to fetch
  output      pred_t      pred,
  output      logic       nop_advance,
  // resolution from execute
  input  wire resolve_t   resolve,
  // allocation request to the branch target buffer
  output      logic       alloc_req
);
  localparam int IDX_W = $clog2(ENTRIES);

  // =====================================================================
  // decode of branch class and direction
  wire         is_cond   = lookup.kind == BR_COND;
  wire         is_uncond = lookup.kind == BR_UNCOND;
  wire         is_ind    = lookup.kind == BR_INDIRECT;
  // backward test
  // equal addresses count as backward, so a branch to itself is a loop
  wire         backward  = lookup.target <= lookup.pc;
  wire         m_dir     = mode == `MODE_DIRECTION;
  wire         m_dyn     = mode == `MODE_DYNAMIC;
  wire         m_noh     = !m_dir && !m_dyn;
  wire         dyn_taken;
  // counter index skips the two byte-offset bits of the address
  wire [IDX_W-1:0] rd_idx = lookup.pc[IDX_W+1:2];
  wire [IDX_W-1:0] wr_idx = resolve.pc[IDX_W+1:2];
  // only conditional resolutions train the counters
  wire         train_en  = resolve.valid && resolve.kind == BR_COND;

  cond_counter_table #(
    .ENTRIES (ENTRIES),
    .IDX_W   (IDX_W)
  ) u_ctr (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .rd_idx   (rd_idx),
    .rd_taken (dyn_taken),
    .wr_en    (train_en),
    .wr_idx   (wr_idx),
    .wr_taken (resolve.taken)
  );

  // =====================================================================
  // static direction choice
  wire static_taken;
  wire cond_taken;
  wire dir_taken = backward;
  assign cond_taken = m_dir ? dir_taken : (m_dyn ? dyn_taken : 1'h0);
  assign static_taken = is_uncond ? 1'h1 : (is_ind ? 1'h0 : cond_taken);

  // buffer hit wins, otherwise static path
  wire       hit_taken = lookup.buf_hit ? lookup.buf_taken : static_taken;
  pred_src_t src_sel;
  assign src_sel = lookup.buf_hit ? SRC_BUFFER :
                   (is_cond && m_dyn) ? SRC_DYNAMIC : SRC_STATIC;
  wire       br_valid  = lookup.valid && lookup.kind != BR_NONE;
  // spin-wait hint is a plain pointer advance
  wire       pause_hit = lookup.valid && lookup.kind == BR_NONE && lookup.is_pause;

  // =====================================================================
  // next values of the registered outputs
  pred_t pred_nxt;
  wire   nop_nxt;
  wire   alloc_nxt;
  assign pred_nxt.valid = br_valid;
  assign pred_nxt.taken = br_valid && hit_taken;
  assign pred_nxt.src   = br_valid ? src_sel : SRC_NONE;
  assign nop_nxt        = pause_hit;
  assign alloc_nxt      = resolve.valid && resolve.taken;

  // =====================================================================
  // registered outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pred        <= '0;
      nop_advance <= 1'h0;
      alloc_req   <= 1'h0;
    end else begin
      pred        <= pred_nxt;
      nop_advance <= nop_nxt;
      alloc_req   <= alloc_nxt;
    end
  end

  // =====================================================================
  // checks
  // unconditional taken
  AST_UNCOND_TAKEN: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_uncond && !lookup.buf_hit |=> pred.valid && pred.taken)
    else $error("unconditional branch not predicted taken");
  AST_IND_NT: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_ind && !lookup.buf_hit |=> pred.valid && !pred.taken)
    else $error("indirect branch predicted taken");
  AST_BACK_TAKEN: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_cond && !lookup.buf_hit && m_dir && backward |=> pred.taken)
    else $error("backward conditional not taken");
  AST_FWD_NT: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_cond && !lookup.buf_hit && m_dir && !backward |=> !pred.taken)
    else $error("forward conditional predicted taken");
  AST_DYN_SRC: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_cond && !lookup.buf_hit && m_dyn |=> pred.src == SRC_DYNAMIC)
    else $error("dynamic mode did not use dynamic prediction");
  AST_NO_ALLOC_NT: assert property (@(posedge clk_sys) disable iff (!resetn)
    alloc_req |-> $past(resolve.valid) && $past(resolve.taken))
    else $error("allocation for a branch never taken");
  AST_NOHEUR: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_cond && !lookup.buf_hit && m_noh |=> !pred.taken)
    else $error("heuristic applied in heuristic-free mode");
  AST_HIT_FOLLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
    br_valid && lookup.buf_hit |=> pred.src == SRC_BUFFER && pred.taken == $past(lookup.buf_taken))
    else $error("buffer prediction not followed");
  AST_PAUSE_NOP: assert property (@(posedge clk_sys) disable iff (!resetn)
    pause_hit |=> nop_advance && !pred.valid)
    else $error("pause hint had a side effect");

  // =====================================================================
  // checks on sources, idle cycles and allocation
  // taken resolution allocates
  AST_ALLOC_TAKEN: assert property (@(posedge clk_sys) disable iff (!resetn)
    resolve.valid && resolve.taken
    |=> alloc_req)
    else $error("taken resolution did not request allocation");
  AST_ALLOC_QUIET: assert property (@(posedge clk_sys) disable iff (!resetn)
    !resolve.valid
    |=> !alloc_req)
    else $error("allocation without a resolution");
  AST_NT_NO_ALLOC: assert property (@(posedge clk_sys) disable iff (!resetn)
    resolve.valid && !resolve.taken
    |=> !alloc_req)
    else $error("allocation after a not-taken resolution");
  AST_NONE_NO_PRED: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && lookup.kind == BR_NONE
    |=> !pred.valid && !pred.taken && pred.src == SRC_NONE)
    else $error("prediction issued for a non-branch");
  AST_PAUSE_ONLY: assert property (@(posedge clk_sys) disable iff (!resetn)
    !pause_hit
    |=> !nop_advance)
    else $error("pointer advance without a spin-wait hint");
  AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (!resetn)
    !lookup.valid
    |=> !pred.valid)
    else $error("prediction without a lookup");
  AST_VALID_FOLLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
    br_valid
    |=> pred.valid)
    else $error("branch lookup not answered");
  AST_STATIC_SRC: assert property (@(posedge clk_sys) disable iff (!resetn)
    br_valid && !lookup.buf_hit && !(is_cond && m_dyn)
    |=> pred.src == SRC_STATIC)
    else $error("buffer miss not resolved by the static path");
  AST_UNCOND_FWD: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_uncond && !lookup.buf_hit && !backward
    |=> pred.taken)
    else $error("forward unconditional branch not taken");
  AST_IND_BACK_NT: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_ind && !lookup.buf_hit && backward
    |=> !pred.taken)
    else $error("backward indirect branch predicted taken");
  AST_DYN_FOLLOW: assert property (@(posedge clk_sys) disable iff (!resetn)
    br_valid && is_cond && !lookup.buf_hit && m_dyn
    |=> pred.taken == $past(dyn_taken))
    else $error("dynamic prediction not followed");
  AST_DYN_NOT_DIR: assert property (@(posedge clk_sys) disable iff (!resetn)
    br_valid && is_cond && !lookup.buf_hit && m_dyn && backward && !dyn_taken
    |=> !pred.taken)
    else $error("jump direction used in dynamic mode");
  AST_SAME_ADDR_BACK: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_cond && !lookup.buf_hit && m_dir && lookup.target == lookup.pc
    |=> pred.taken)
    else $error("branch to its own address not taken");
  AST_NEXT_ADDR_FWD: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_cond && !lookup.buf_hit && m_dir && lookup.target == lookup.pc + 32'h4
    |=> !pred.taken)
    else $error("branch to the next word predicted taken");
  AST_NOHEUR_SRC: assert property (@(posedge clk_sys) disable iff (!resetn)
    lookup.valid && is_cond && !lookup.buf_hit && m_noh
    |=> pred.src == SRC_STATIC)
    else $error("heuristic-free mode used another source");
endmodule // static_branch_predictor

// *** dv/fetch_side_model.sv ***
// =====================================================================
// fetch, decode and buffer side facing the predictor
module fetch_side_model
  import sbp_pkg::*;
(
  // clock
  input  wire logic     clk_sys,
  // requests to the predictor
  output      lookup_t  lookup,
  output      resolve_t resolve,
  // allocation from the predictor
  input  wire logic     alloc_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] entry_pc_r;
  logic        entry_vld_r;
  logic [31:0] last_pc_r;

  initial begin
    lookup      = '0;
    resolve     = '0;
    entry_vld_r = 1'h0;
  end

  always @(posedge clk_sys) begin
    if (resolve.valid) last_pc_r <= resolve.pc;
    if (alloc_req) begin
      entry_pc_r  <= last_pc_r;
      entry_vld_r <= 1'h1;
    end
  end

  // released fields show inverted values, not the last ones
  task automatic look(input br_kind_t k, input logic [31:0] pc, tgt, input logic pause);
    lookup_t t;
    t.valid     = 1'h1;
    t.kind      = k;
    t.pc        = pc;
    t.target    = tgt;
    t.buf_hit   = entry_vld_r && (entry_pc_r == pc);
    t.buf_taken = 1'h1;
    t.is_pause  = pause;
    lookup      = t;
    @(negedge clk_sys);
    t           = ~t;
    t.valid     = 1'h0;
    lookup      = t;
  endtask

  task automatic res(input br_kind_t k, input logic [31:0] pc, input logic tk);
    resolve_t t;
    t       = '{valid: 1'h1, kind: k, pc: pc, taken: tk};
    resolve = t;
    @(negedge clk_sys);
    t       = ~t;
    t.valid = 1'h0;
    resolve = t;
  endtask
endmodule // fetch_side_model

// *** dv/static_branch_predictor_tb_top.sv ***
module static_branch_predictor_tb_top
  import sbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys;
  logic       resetn;
  logic [1:0] mode;
  lookup_t    lookup;
  resolve_t   resolve;
  pred_t      pred;
  logic       nop_advance;
  logic       alloc_req;
  int         n_fail;
  int         comparisons;

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  static_branch_predictor dut_u (.clk_sys(clk_sys), .resetn(resetn), .mode(mode), .lookup(lookup),
    .pred(pred), .nop_advance(nop_advance), .resolve(resolve), .alloc_req(alloc_req));
  fetch_side_model fm_u (.clk_sys(clk_sys), .lookup(lookup), .resolve(resolve), .alloc_req(alloc_req));

  // =====================================================================
  // shared checks
  task automatic chk(input string nm, input logic [4:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one lookup judged while its answer stands, then one idle cycle judged
  task automatic lk(br_kind_t k, logic [31:0] pc, tgt, logic pause, logic v, tk, pred_src_t s, logic nop);
    fm_u.look(k, pc, tgt, pause);
    chk("pred", {v, tk, s, nop}, {pred.valid, pred.taken, pred.src, nop_advance});
    @(negedge clk_sys);
    chk("pred_idle", 5'h00, {pred.valid, pred.taken, pred.src, nop_advance});
  endtask

  task automatic rs(br_kind_t k, logic [31:0] pc, logic tk);
    fm_u.res(k, pc, tk);
    chk("alloc_req", {4'h0, tk}, {4'h0, alloc_req});
    @(negedge clk_sys);
  endtask

  // =====================================================================
  // scenarios
  task automatic sc_direction;
    mode = 2'h0;
    lk(BR_COND, 32'h100, 32'h100, 1'h0, 1'h1, 1'h1, SRC_STATIC, 1'h0);
    lk(BR_COND, 32'h100, 32'hF0, 1'h0, 1'h1, 1'h1, SRC_STATIC, 1'h0);
    lk(BR_COND, 32'h100, 32'h104, 1'h0, 1'h1, 1'h0, SRC_STATIC, 1'h0);
    lk(BR_UNCOND, 32'h100, 32'h200, 1'h0, 1'h1, 1'h1, SRC_STATIC, 1'h0);
    lk(BR_INDIRECT, 32'h200, 32'h100, 1'h0, 1'h1, 1'h0, SRC_STATIC, 1'h0);
  endtask

  // trained through an alias of the same counter index
  task automatic sc_dynamic;
    mode = 2'h1;
    lk(BR_COND, 32'h1010, 32'h1000, 1'h0, 1'h1, 1'h0, SRC_DYNAMIC, 1'h0);
    rs(BR_COND, 32'h2010, 1'h1);
    lk(BR_COND, 32'h1010, 32'h1000, 1'h0, 1'h1, 1'h1, SRC_DYNAMIC, 1'h0);
    lk(BR_UNCOND, 32'h1010, 32'h1000, 1'h0, 1'h1, 1'h1, SRC_STATIC, 1'h0);
  endtask

  task automatic sc_noheur;
    for (int m = 2; m < 4; m++) begin
      mode = m[1:0];
      lk(BR_COND, 32'h300, 32'h2F0, 1'h0, 1'h1, 1'h0, SRC_STATIC, 1'h0);
    end
  endtask

  task automatic sc_alloc;
    mode = 2'h0;
    rs(BR_COND, 32'h400, 1'h0);
    lk(BR_COND, 32'h400, 32'h3F0, 1'h0, 1'h1, 1'h1, SRC_STATIC, 1'h0);
    rs(BR_COND, 32'h400, 1'h1);
    lk(BR_COND, 32'h400, 32'h500, 1'h0, 1'h1, 1'h1, SRC_BUFFER, 1'h0);
    lk(BR_COND, 32'h404, 32'h500, 1'h0, 1'h1, 1'h0, SRC_STATIC, 1'h0);
  endtask

  task automatic sc_pause;
    lk(BR_NONE, 32'h500, 32'h0, 1'h1, 1'h0, 1'h0, SRC_NONE, 1'h1);
    lk(BR_NONE, 32'h504, 32'h0, 1'h0, 1'h0, 1'h0, SRC_NONE, 1'h0);
  endtask

  // reset in mid-run: requests ignored, counters back to weak not-taken
  task automatic sc_reset;
    mode   = 2'h1;
    resetn = 1'h0;
    fm_u.look(BR_UNCOND, 32'h1010, 32'h2000, 1'h0);
    chk("pred_in_reset", 5'h00, {pred.valid, pred.taken, pred.src, nop_advance});
    fm_u.res(BR_COND, 32'h1010, 1'h1);
    chk("alloc_in_reset", 5'h00, {4'h0, alloc_req});
    resetn = 1'h1;
    @(negedge clk_sys);
    lk(BR_COND, 32'h1010, 32'h1000, 1'h0, 1'h1, 1'h0, SRC_DYNAMIC, 1'h0);
  endtask

  task automatic give_verdict;
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    n_fail      = 0;
    comparisons = 0;
    resetn      = 1'h0;
    mode        = 2'h0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'h1;
    @(negedge clk_sys);
    sc_direction();
    sc_dynamic();
    sc_noheur();
    sc_alloc();
    sc_pause();
    sc_reset();
    give_verdict();
  end
endmodule // static_branch_predictor_tb_top
